// *** logic/bcw_map.svh ***
// offsets, field positions and reset values of the bridge header window registers
`ifndef BCW_MAP_SVH
`define BCW_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define BCW_OFF_PF_LOW 8'h24
`define BCW_OFF_PF_START_HI 8'h28
`define BCW_OFF_PF_END_HI 8'h2c
`define BCW_OFF_IO_HI 8'h30
`define BCW_OFF_CAP_PTR 8'h34
`define BCW_OFF_ROM_BASE 8'h38
`define BCW_OFF_IRQ_CTRL 8'h3c

// ****************************************
// field positions
// ****************************************
`define BCW_PF_START_CAP_LSB 0
`define BCW_PF_START_LSB 4
`define BCW_PF_END_CAP_LSB 16
`define BCW_PF_END_LSB 20
`define BCW_IO_START_LSB 0
`define BCW_IO_END_LSB 16
`define BCW_IRQ_LINE_LSB 0
`define BCW_IRQ_PIN_LSB 8
`define BCW_PARITY_RESP_BIT 16
`define BCW_SERR_FWD_BIT 17

// ****************************************
// reset and fixed values
// ****************************************
`define BCW_PF_ADDR64_CODE 4'h1
`define BCW_PF_FIELD_RST 12'h000
`define BCW_UPPER32_RST 32'h0000_0000
`define BCW_IO_UPPER_RST 16'h0000
`define BCW_CAP_PTR_NORMAL 8'h80
`define BCW_CAP_PTR_COMPAT 8'h90
`define BCW_ROM_BASE_VALUE 32'h0000_0000
`define BCW_IRQ_LINE_RST 8'h00
`define BCW_IRQ_PIN_VALUE 8'h01
`define BCW_CTRL_BIT_RST 1'h0
`define BCW_PF_END_LOW_FILL 20'hfffff
`define BCW_PF_START_LOW_FILL 20'h00000
`define BCW_IO_LOW_ZERO 16'h0000

`endif

// *** logic/bcw_pkg.sv ***
// types shared by the bridge header window register bank
package bcw_pkg;

  // register slot selected by a configuration access
  typedef enum logic [2:0] {
    BCW_SLOT_PF_LOW,
    BCW_SLOT_PF_START_HI,
    BCW_SLOT_PF_END_HI,
    BCW_SLOT_IO_HI,
    BCW_SLOT_CAP_PTR,
    BCW_SLOT_ROM_BASE,
    BCW_SLOT_IRQ_CTRL,
    BCW_SLOT_NONE
  } bcw_slot_e;

  typedef logic [31:0] bcw_word_t;

endpackage : bcw_pkg

// *** logic/bcw_field_reg.sv ***
// one writable register field with per-byte write enables
`timescale 1ns/10ps

module bcw_field_reg #(
  parameter int WIDTH = 8,
  parameter int LSB = 0,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic write_hit,
  input wire logic [3:0] byte_en,
  input wire logic [31:0] wdata,
  output logic [WIDTH-1:0] field_reg
);

  // the field must sit inside one 32-bit configuration word, refused at elaboration
  if (WIDTH < 1 || LSB < 0 || LSB + WIDTH > 32)
  begin : g_bad_field
    $error("bcw_field_reg: field does not fit in a 32-bit word");
  end

  // ****************************************
  // per-bit storage
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      // each bit follows the byte lane it lives in, so partial writes keep the rest
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          field_reg[gi] <= RESET_VALUE[gi];
        else if (write_hit && byte_en[(LSB + gi) / 8])
          field_reg[gi] <= wdata[LSB + gi];
      end
    end
  endgenerate

endmodule : bcw_field_reg

// *** logic/bcw_window_regs.sv ***
// bridge header window registers: prefetch and I/O windows, pointers, irq and bridge control
`timescale 1ns/10ps
`include "bcw_map.svh"

module bcw_window_regs (
  input wire logic clock,
  input wire logic rst_n,
  // configuration access port
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_hit,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  // compatibility setting pin and low halves of the I/O window
  input wire logic compat_mode_in,
  input wire logic [15:0] io_start_low_in,
  input wire logic [15:0] io_end_low_in,
  // secondary bus error events
  input wire logic secondary_system_error_in,
  input wire logic secondary_error_is_fatal,
  input wire logic secondary_parity_error,
  // window outputs for the address decode
  output logic [63:0] pf_window_start,
  output logic [63:0] pf_window_end,
  output logic [31:0] io_window_start,
  output logic [31:0] io_window_end,
  // bridge control effects
  output logic parity_response_enable,
  output logic secondary_parity_report,
  output logic err_fatal_msg_req,
  output logic err_nonfatal_msg_req,
  output logic [7:0] irq_routing_value
);

  // ****************************************
  // access decode
  // ****************************************
  bcw_pkg::bcw_slot_e slot;
  logic wr_pf_low;
  logic wr_pf_start_hi;
  logic wr_pf_end_hi;
  logic wr_io_hi;
  logic wr_irq_ctrl;

  // dword decode on the byte address; low two address bits are don't care
  always_comb
  begin
    case ({cfg_addr[7:2], 2'b00})
      `BCW_OFF_PF_LOW: slot = bcw_pkg::BCW_SLOT_PF_LOW;
      `BCW_OFF_PF_START_HI: slot = bcw_pkg::BCW_SLOT_PF_START_HI;
      `BCW_OFF_PF_END_HI: slot = bcw_pkg::BCW_SLOT_PF_END_HI;
      `BCW_OFF_IO_HI: slot = bcw_pkg::BCW_SLOT_IO_HI;
      `BCW_OFF_CAP_PTR: slot = bcw_pkg::BCW_SLOT_CAP_PTR;
      `BCW_OFF_ROM_BASE: slot = bcw_pkg::BCW_SLOT_ROM_BASE;
      `BCW_OFF_IRQ_CTRL: slot = bcw_pkg::BCW_SLOT_IRQ_CTRL;
      default: slot = bcw_pkg::BCW_SLOT_NONE;
    endcase
  end

  // hit tells the rest of the header whether this bank owns the offset
  assign cfg_hit = (slot != bcw_pkg::BCW_SLOT_NONE);

  // write strobes per register; read-only slots have none at all
  assign wr_pf_low = cfg_wr_en && (slot == bcw_pkg::BCW_SLOT_PF_LOW);
  assign wr_pf_start_hi = cfg_wr_en && (slot == bcw_pkg::BCW_SLOT_PF_START_HI);
  assign wr_pf_end_hi = cfg_wr_en && (slot == bcw_pkg::BCW_SLOT_PF_END_HI);
  assign wr_io_hi = cfg_wr_en && (slot == bcw_pkg::BCW_SLOT_IO_HI);
  assign wr_irq_ctrl = cfg_wr_en && (slot == bcw_pkg::BCW_SLOT_IRQ_CTRL);

  // ****************************************
  // prefetchable window, low word
  // ****************************************
  logic [11:0] pf_start_field_reg;
  logic [11:0] pf_end_field_reg;

  // start address bits 31:20 live in register bits 15:4
  bcw_field_reg #(
    .WIDTH(12),
    .LSB(`BCW_PF_START_LSB),
    .RESET_VALUE(`BCW_PF_FIELD_RST)
  ) u_pf_start_field (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_pf_low),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(pf_start_field_reg)
  );

  // end address bits 31:20 live in register bits 31:20
  bcw_field_reg #(
    .WIDTH(12),
    .LSB(`BCW_PF_END_LSB),
    .RESET_VALUE(`BCW_PF_FIELD_RST)
  ) u_pf_end_field (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_pf_low),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(pf_end_field_reg)
  );

  // ****************************************
  // prefetchable window, upper words
  // ****************************************
  logic [31:0] pf_start_high_reg;
  logic [31:0] pf_end_high_reg;

  bcw_field_reg #(
    .WIDTH(32),
    .LSB(0),
    .RESET_VALUE(`BCW_UPPER32_RST)
  ) u_pf_start_high (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_pf_start_hi),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(pf_start_high_reg)
  );

  bcw_field_reg #(
    .WIDTH(32),
    .LSB(0),
    .RESET_VALUE(`BCW_UPPER32_RST)
  ) u_pf_end_high (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_pf_end_hi),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(pf_end_high_reg)
  );

  // ****************************************
  // I/O window, upper halves
  // ****************************************
  logic [15:0] io_start_high_reg;
  logic [15:0] io_end_high_reg;

  bcw_field_reg #(
    .WIDTH(16),
    .LSB(`BCW_IO_START_LSB),
    .RESET_VALUE(`BCW_IO_UPPER_RST)
  ) u_io_start_high (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_io_hi),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(io_start_high_reg)
  );

  bcw_field_reg #(
    .WIDTH(16),
    .LSB(`BCW_IO_END_LSB),
    .RESET_VALUE(`BCW_IO_UPPER_RST)
  ) u_io_end_high (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_io_hi),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(io_end_high_reg)
  );

  // ****************************************
  // interrupt routing byte and bridge control
  // ****************************************
  logic [7:0] irq_line_reg;
  logic [1:0] bridge_ctrl_reg;

  // routing byte is written by software and driven out on irq_routing_value
  bcw_field_reg #(
    .WIDTH(8),
    .LSB(`BCW_IRQ_LINE_LSB),
    .RESET_VALUE(`BCW_IRQ_LINE_RST)
  ) u_irq_line (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_irq_ctrl),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(irq_line_reg)
  );

  // bit 0 is parity response enable, bit 1 is system error forwarding enable
  bcw_field_reg #(
    .WIDTH(2),
    .LSB(`BCW_PARITY_RESP_BIT),
    .RESET_VALUE({`BCW_CTRL_BIT_RST, `BCW_CTRL_BIT_RST})
  ) u_bridge_ctrl (
    .clock(clock),
    .rst_n(rst_n),
    .write_hit(wr_irq_ctrl),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .field_reg(bridge_ctrl_reg)
  );

  assign irq_routing_value = irq_line_reg;
  assign parity_response_enable = bridge_ctrl_reg[0];

  // ****************************************
  // compatibility setting synchroniser
  // ****************************************
  logic [2:0] compat_sync_reg;
  logic compat_mode_reg;

  // pin is asynchronous to the bridge clock
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      compat_sync_reg <= 3'h0;
    else
      compat_sync_reg <= {compat_sync_reg[1:0], compat_mode_in};
  end

  // accept a change only once stages two and three agree, so a one-sample glitch never flips it
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      compat_mode_reg <= 1'b0;
    else if (compat_sync_reg[1] == compat_sync_reg[2])
      compat_mode_reg <= compat_sync_reg[2];
  end

  // ****************************************
  // secondary system error forwarding
  // ****************************************
  logic [2:0] serr_sync_reg;
  logic serr_level_reg;
  logic serr_fwd_next;

  // the error input is a pin; it is active high once it reaches this block
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      serr_sync_reg <= 3'h0;
    else
      serr_sync_reg <= {serr_sync_reg[1:0], secondary_system_error_in};
  end

  // filtered level of the error pin
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      serr_level_reg <= 1'b0;
    else if (serr_sync_reg[1] == serr_sync_reg[2])
      serr_level_reg <= serr_sync_reg[2];
  end

  // one message per assertion: a held error pin does not flood the upstream link
  assign serr_fwd_next = serr_sync_reg[1] && serr_sync_reg[2] && !serr_level_reg &&
    bridge_ctrl_reg[1];

  // message requests are one-cycle pulses, severity chosen by the error source
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      err_fatal_msg_req <= 1'b0;
      err_nonfatal_msg_req <= 1'b0;
    end
    else
    begin
      err_fatal_msg_req <= serr_fwd_next && secondary_error_is_fatal;
      err_nonfatal_msg_req <= serr_fwd_next && !secondary_error_is_fatal;
    end
  end

  // ****************************************
  // secondary parity error response
  // ****************************************
  // with the enable clear, detected parity errors are simply dropped
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      secondary_parity_report <= 1'b0;
    else
      secondary_parity_report <= secondary_parity_error && bridge_ctrl_reg[0];
  end

  // ****************************************
  // window address assembly
  // ****************************************
  // writable bits of the outputs come straight from the field flops, so decode sees writes one cycle later
  assign pf_window_start = {pf_start_high_reg, pf_start_field_reg,
    `BCW_PF_START_LOW_FILL};
  assign pf_window_end = {pf_end_high_reg, pf_end_field_reg,
    `BCW_PF_END_LOW_FILL};
  assign io_window_start = {io_start_high_reg, io_start_low_in};
  assign io_window_end = {io_end_high_reg, io_end_low_in};

  // ****************************************
  // read data
  // ****************************************
  bcw_pkg::bcw_word_t rdata_next;

  // reserved bits and unmapped offsets read as zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (slot)
      bcw_pkg::BCW_SLOT_PF_LOW:
      begin
        rdata_next[`BCW_PF_START_CAP_LSB +: 4] = `BCW_PF_ADDR64_CODE;
        rdata_next[`BCW_PF_START_LSB +: 12] = pf_start_field_reg;
        rdata_next[`BCW_PF_END_CAP_LSB +: 4] = `BCW_PF_ADDR64_CODE;
        rdata_next[`BCW_PF_END_LSB +: 12] = pf_end_field_reg;
      end
      bcw_pkg::BCW_SLOT_PF_START_HI: rdata_next = pf_start_high_reg;
      bcw_pkg::BCW_SLOT_PF_END_HI: rdata_next = pf_end_high_reg;
      bcw_pkg::BCW_SLOT_IO_HI:
      begin
        rdata_next[`BCW_IO_START_LSB +: 16] = io_start_high_reg;
        rdata_next[`BCW_IO_END_LSB +: 16] = io_end_high_reg;
      end
      bcw_pkg::BCW_SLOT_CAP_PTR:
      begin
        // compatibility setting skips the PCI-X capability in the list
        rdata_next[7:0] = compat_mode_reg ? `BCW_CAP_PTR_COMPAT : `BCW_CAP_PTR_NORMAL;
      end
      bcw_pkg::BCW_SLOT_ROM_BASE: rdata_next = `BCW_ROM_BASE_VALUE;
      bcw_pkg::BCW_SLOT_IRQ_CTRL:
      begin
        rdata_next[`BCW_IRQ_LINE_LSB +: 8] = irq_line_reg;
        rdata_next[`BCW_IRQ_PIN_LSB +: 8] = `BCW_IRQ_PIN_VALUE;
        rdata_next[`BCW_PARITY_RESP_BIT +: 2] = bridge_ctrl_reg;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read data is registered and qualified by a one-cycle valid
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cfg_rdata <= 32'h0000_0000;
    else if (cfg_rd_en)
      cfg_rdata <= rdata_next;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cfg_rd_valid <= 1'b0;
    else
      cfg_rd_valid <= cfg_rd_en;
  end

endmodule : bcw_window_regs

// *** tb/bcw_window_regs_chk.sv ***
// checker for the bridge header window register bank
`timescale 1ns/10ps

module bcw_window_regs_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_valid,
  input wire logic secondary_parity_error,
  input wire logic [63:0] pf_window_start,
  input wire logic [63:0] pf_window_end,
  input wire logic [31:0] io_window_start,
  input wire logic [31:0] io_window_end,
  input wire logic parity_response_enable,
  input wire logic secondary_parity_report
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // a read or a full-word write of one dword slot
  sequence s_rd(logic [5:0] k);
    cfg_rd_en && (cfg_addr[7:2] == k);
  endsequence
  sequence s_wr(logic [5:0] k);
    cfg_wr_en && (cfg_addr[7:2] == k) && (cfg_byte_en == 4'hf);
  endsequence

  property p_nibble;
    s_rd(6'h09) |=> cfg_rd_valid && cfg_rdata[19:16] == 4'h1 && cfg_rdata[3:0] == 4'h1;
  endproperty
  a_nibble: assert property (p_nibble) else $error("address nibbles wrong");
  property p_start_low;
    pf_window_start[19:0] == 20'h00000;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start low bits");
  property p_end_low;
    pf_window_end[19:0] == 20'hfffff;
  endproperty
  a_end_low: assert property (p_end_low) else $error("end low bits");
  // a full write of the low prefetch word moves both writable fields
  property p_start_field;
    s_wr(6'h09) |=> pf_window_start[31:20] == $past(cfg_wdata[15:4]);
  endproperty
  a_start_field: assert property (p_start_field) else $error("start field");
  property p_end_field;
    s_wr(6'h09) |=> pf_window_end[31:20] == $past(cfg_wdata[31:20]);
  endproperty
  a_end_field: assert property (p_end_field) else $error("end field");
  property p_start_hi;
    s_wr(6'h0a) |=> pf_window_start[63:32] == $past(cfg_wdata);
  endproperty
  a_start_hi: assert property (p_start_hi) else $error("start high word");
  property p_end_hi;
    s_wr(6'h0b) |=> pf_window_end[63:32] == $past(cfg_wdata);
  endproperty
  a_end_hi: assert property (p_end_hi) else $error("end high word");
  // both io halves land together on a full write
  property p_io_hi;
    s_wr(6'h0c) |=> io_window_start[31:16] == $past(cfg_wdata[15:0])
      && io_window_end[31:16] == $past(cfg_wdata[31:16]);
  endproperty
  a_io_hi: assert property (p_io_hi) else $error("io high halves");
  property p_rom;
    s_rd(6'h0e) |=> cfg_rd_valid && cfg_rdata == 32'h0000_0000;
  endproperty
  a_rom: assert property (p_rom) else $error("option rom not zero");
  property p_pin;
    s_rd(6'h0f) |=> cfg_rdata[15:8] == 8'h01;
  endproperty
  a_pin: assert property (p_pin) else $error("irq pin byte");
  property p_parity;
    secondary_parity_error |=> secondary_parity_report == $past(parity_response_enable);
  endproperty
  a_parity: assert property (p_parity) else $error("parity report");
endmodule : bcw_window_regs_chk

bind bcw_window_regs bcw_window_regs_chk bcw_window_regs_chk_i (
  .clock(clock), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
  .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
  .secondary_parity_error(secondary_parity_error), .pf_window_start(pf_window_start),
  .pf_window_end(pf_window_end), .io_window_start(io_window_start),
  .io_window_end(io_window_end), .parity_response_enable(parity_response_enable),
  .secondary_parity_report(secondary_parity_report)
);

// *** tb/bcw_window_regs_test.sv ***
// self-checking bench for the bridge header window register bank
`timescale 1ns/10ps

module bcw_window_regs_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, compat_mode_in = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_byte_en = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [15:0] io_start_low_in = 16'h0, io_end_low_in = 16'h0;
  logic secondary_system_error_in = 1'b0, secondary_error_is_fatal = 1'b0;
  logic secondary_parity_error = 1'b0;
  logic cfg_hit, cfg_rd_valid, parity_response_enable, secondary_parity_report;
  logic err_fatal_msg_req, err_nonfatal_msg_req;
  logic [31:0] cfg_rdata, io_window_start, io_window_end;
  logic [63:0] pf_window_start, pf_window_end;
  logic [7:0] irq_routing_value;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] m [16];

  bcw_window_regs bcw_window_regs_i (
    .clock(clock), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .compat_mode_in(compat_mode_in), .io_start_low_in(io_start_low_in),
    .io_end_low_in(io_end_low_in), .secondary_system_error_in(secondary_system_error_in),
    .secondary_error_is_fatal(secondary_error_is_fatal),
    .secondary_parity_error(secondary_parity_error), .pf_window_start(pf_window_start),
    .pf_window_end(pf_window_end), .io_window_start(io_window_start),
    .io_window_end(io_window_end), .parity_response_enable(parity_response_enable),
    .secondary_parity_report(secondary_parity_report),
    .err_fatal_msg_req(err_fatal_msg_req), .err_nonfatal_msg_req(err_nonfatal_msg_req),
    .irq_routing_value(irq_routing_value)
  );

  // ********
  // clock, timeout and reporting
  // ********
  always #2 clock = ~clock;

  // whole run is about eight hundred cycles, so this only cuts a hang
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      complete_run();
    end
  end

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // ********
  // reference model: writable bits per slot plus fixed read values
  // ********
  function automatic logic [31:0] wmask(input int k);
    case (k)
      9: return 32'hfff0_fff0;
      10, 11, 12: return 32'hffff_ffff;
      15: return 32'h0003_00ff;
      default: return 32'h0000_0000;
    endcase
  endfunction : wmask

  function automatic logic [31:0] exp_rd(input int k);
    logic [31:0] fix;
    case (k)
      9: fix = 32'h0001_0001;
      13: fix = compat_mode_in ? 32'h0000_0090 : 32'h0000_0080;
      15: fix = 32'h0000_0100;
      default: fix = 32'h0000_0000;
    endcase
    return ((k > 8 && k < 16) ? (m[k] & wmask(k)) : 32'h0) | fix;
  endfunction : exp_rd

  // one access cycle; a read in the same cycle as a write sees the old word
  task acc(input bit w, input bit r, input logic [7:0] a, input logic [3:0] be,
           input logic [31:0] d);
    int k;
    logic [31:0] e, mk;
    k = a[7:2];
    e = exp_rd(k);
    mk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask(k);
    @(negedge clock);
    cfg_wr_en = w;
    cfg_rd_en = r;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    io_start_low_in = $urandom;
    io_end_low_in = $urandom;
    @(negedge clock);
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    if (w && k > 8 && k < 16) m[k] = (m[k] & ~mk) | (d & mk);
    chk(cfg_rd_valid, r);
    chk(cfg_hit, k > 8 && k < 16);
    if (r) chk(cfg_rdata, e);
    chk(pf_window_start, {m[10], m[9][15:4], 20'h00000});
    chk(pf_window_end, {m[11], m[9][31:20], 20'hfffff});
    chk({io_window_start, io_window_end},
        {m[12][15:0], io_start_low_in, m[12][31:16], io_end_low_in});
    chk({parity_response_enable, irq_routing_value}, {m[15][16], m[15][7:0]});
  endtask : acc

  task do_reset;
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    for (int k = 0; k < 16; k++) m[k] = 32'h0;
  endtask : do_reset

  // read every slot from 20h to 40h, unmapped ends included
  task read_all;
    for (int k = 8; k < 17; k++) acc(1'b0, 1'b1, 8'(k * 4), 4'h0, 32'h0);
  endtask : read_all

  // error pin pulse: count message pulses over a bounded window
  task serr(input logic f);
    int nf, nn;
    nf = 0;
    nn = 0;
    @(negedge clock);
    secondary_error_is_fatal = f;
    secondary_system_error_in = 1'b1;
    repeat (10)
    begin
      @(negedge clock);
      nf += (err_fatal_msg_req === 1'b1);
      nn += (err_nonfatal_msg_req === 1'b1);
    end
    secondary_system_error_in = 1'b0;
    repeat (6) @(negedge clock);
    chk({nf[7:0], nn[7:0]}, {7'h0, m[15][17] & f, 7'h0, m[15][17] & ~f});
  endtask : serr

  task parity;
    @(negedge clock);
    secondary_parity_error = 1'b1;
    @(negedge clock);
    secondary_parity_error = 1'b0;
    chk(secondary_parity_report, m[15][16]);
  endtask : parity

  // ********
  // main sequence
  // ********
  initial
  begin
    void'($urandom(14250));
    do_reset();
    read_all();
    $display("reset values done");
    foreach (m[k]) acc(1'b1, 1'b1, 8'(k * 4), 4'hf, 32'hffff_ffff);
    read_all();
    parity();
    serr(1'b1);
    serr(1'b0);
    $display("all ones writes done");
    acc(1'b1, 1'b0, 8'h3c, 4'h4, 32'h0);
    parity();
    serr(1'b1);
    $display("control bits clear done");
    compat_mode_in = 1'b1;
    repeat (8) @(negedge clock);
    acc(1'b0, 1'b1, 8'h34, 4'h0, 32'h0);
    compat_mode_in = 1'b0;
    repeat (8) @(negedge clock);
    acc(1'b0, 1'b1, 8'h34, 4'h0, 32'h0);
    $display("capability pointer done");
    repeat (300) acc($urandom, $urandom, 8'($urandom_range(32, 67)), $urandom, $urandom);
    $display("random accesses done");
    do_reset();
    read_all();
    $display("second reset done");
    complete_run();
  end
endmodule : bcw_window_regs_test
